// *** src/branch_cond_eval.v ***
`include "branch_unit_defines.vh"
`default_nettype none

// ***********************************************************************
// condition evaluation from the status flags
// ***********************************************************************
module branch_cond_eval
(
   input  wire [`SEL_WIDTH-1:0] sel_i,
   input  wire                  carry_i,
   input  wire                  negative_i,
   input  wire                  overflow_i,
   input  wire                  half_carry_i,
   input  wire                  transfer_i,
   output reg                   cond_o,
   output reg                   legal_o
);

   wire sign_lt;

   // signed compare result is n xor v
   assign sign_lt = negative_i ^ overflow_i;

   // one flag test per select code; unknown codes are flagged illegal
   always @*
   begin
      cond_o  = 1'b0;
      legal_o = 1'b1;
      case (sel_i)
         `SEL_SAME_OR_HIGHER:   cond_o = (carry_i == 1'b0);      // see [RULE1]
         `SEL_UNSIGNED_LOWER:   cond_o = (carry_i == 1'b1);      // see [RULE2]
         `SEL_ON_NEGATIVE:      cond_o = (negative_i == 1'b1);   // see [RULE3]
         `SEL_ON_NONNEGATIVE:   cond_o = (negative_i == 1'b0);   // see [RULE4]
         `SEL_SIGNED_GE:        cond_o = (sign_lt == 1'b0);      // see [RULE5]
         `SEL_SIGNED_LT:        cond_o = (sign_lt == 1'b1);      // see [RULE6]
         `SEL_HALF_CARRY_SET:   cond_o = (half_carry_i == 1'b1); // see [RULE7]
         `SEL_HALF_CARRY_CLEAR: cond_o = (half_carry_i == 1'b0); // see [RULE8]
         `SEL_TRANSFER_SET:     cond_o = (transfer_i == 1'b1);   // see [RULE9]
         `SEL_TRANSFER_CLEAR:   cond_o = (transfer_i == 1'b0);   // see [RULE10]
         `SEL_OVERFLOW_SET:     cond_o = (overflow_i == 1'b1);   // see [RULE11]
         default:               legal_o = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

// *** src/branch_target_add.v ***
`include "branch_unit_defines.vh"
`default_nettype none

// ***********************************************************************
// target and fall-through address arithmetic
// ***********************************************************************
module branch_target_add
(
   input  wire [`PC_WIDTH-1:0]     addr_i,
   input  wire [`OFFSET_WIDTH-1:0] offset_i,
   output wire [`PC_WIDTH-1:0]     target_o,
   output wire [`PC_WIDTH-1:0]     next_seq_o
);

   wire [`PC_WIDTH-1:0] offset_ext;

   // sign extension lets the offset reach backward as well as forward
   assign offset_ext = {{(`PC_WIDTH-`OFFSET_WIDTH){offset_i[`OFFSET_WIDTH-1]}},
                        offset_i};                                // see [RULE14]

   // wraps modulo the counter width, as the program counter itself does
   assign target_o   = addr_i + offset_ext + `PC_STEP;            // see [RULE12]
   assign next_seq_o = addr_i + `PC_STEP;

endmodule

`default_nettype wire

// *** src/branch_unit_defines.vh ***
`ifndef BRANCH_UNIT_DEFINES_VH
`define BRANCH_UNIT_DEFINES_VH

// ***********************************************************************
// widths
// ***********************************************************************
`define PC_WIDTH              16
`define OFFSET_WIDTH          7
`define SEL_WIDTH             4
`define REG_ADDR_WIDTH        4
`define REG_DATA_WIDTH        16

// ***********************************************************************
// branch condition select codes
// ***********************************************************************
`define SEL_SAME_OR_HIGHER    4'h0
`define SEL_UNSIGNED_LOWER    4'h1
`define SEL_ON_NEGATIVE       4'h2
`define SEL_ON_NONNEGATIVE    4'h3
`define SEL_SIGNED_GE         4'h4
`define SEL_SIGNED_LT         4'h5
`define SEL_HALF_CARRY_SET    4'h6
`define SEL_HALF_CARRY_CLEAR  4'h7
`define SEL_TRANSFER_SET      4'h8
`define SEL_TRANSFER_CLEAR    4'h9
`define SEL_OVERFLOW_SET      4'ha

// ***********************************************************************
// register offsets
// ***********************************************************************
`define REG_CTRL              4'h0
`define REG_STATUS            4'h1
`define REG_TAKEN_COUNT       4'h2
`define REG_NOT_TAKEN_COUNT   4'h3
`define REG_LAST_TARGET       4'h4
`define REG_LAST_ADDR         4'h5

// ***********************************************************************
// field positions
// ***********************************************************************
`define CTRL_ENABLE_BIT       0
`define CTRL_COUNT_CLR_BIT    1
`define STATUS_BUSY_BIT       0
`define STATUS_LAST_TAKEN_BIT 1
`define STATUS_ILLEGAL_BIT    2

// ***********************************************************************
// reset values and timing
// ***********************************************************************
`define CTRL_RESET            1'b1
`define COUNT_RESET           16'h0000
`define PC_RESET              16'h0000
`define TAKEN_CYCLES          2
`define NOT_TAKEN_CYCLES      1
`define PC_STEP               16'h0001

`endif

// *** src/conditional_branch_unit.v ***
// Functional notes
// [RULE1] same-or-higher taken when carry is 0
// [RULE2] unsigned lower taken when carry is 1
// [RULE3] negative branch taken when negative is 1
// [RULE4] nonnegative branch taken when negative is 0
// [RULE5] signed ge taken when n xor v is 0
// [RULE6] signed lt taken when n xor v is 1
// [RULE7] half-carry-set taken when half carry is 1
// [RULE8] half-carry-clear taken when half carry is 0
// [RULE9] transfer-set taken when transfer flag is 1
// [RULE10] transfer-clear taken when transfer flag is 0
// [RULE11] overflow-set taken when overflow is 1
// [RULE12] taken target is address plus offset plus one
// [RULE13] no flag writes; one or two cycles
// [RULE14] offset sign-extended before the add
// [RULE15] taken branch discards the already fetched instruction
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "branch_unit_defines.vh"
`default_nettype none

module conditional_branch_unit
(
   input  wire                      core_clk_i,
   input  wire                      reset_n_i,
   // branch request from the decoder
   input  wire                      br_valid_i,
   input  wire [`SEL_WIDTH-1:0]     br_sel_i,
   input  wire [`OFFSET_WIDTH-1:0]  br_offset_i,
   input  wire [`PC_WIDTH-1:0]      br_addr_i,
   // status flags, same clock domain
   input  wire                      flag_carry_i,
   input  wire                      flag_negative_i,
   input  wire                      flag_overflow_i,
   input  wire                      flag_half_carry_i,
   input  wire                      flag_transfer_i,
   // program counter update
   output reg                       br_done_o,
   output reg                       br_taken_o,
   output reg                       pc_load_o,
   output reg  [`PC_WIDTH-1:0]      program_counter_o,
   output reg                       fetch_flush_o,
   output wire                      br_busy_o,
   output reg                       flag_write_en_o,
   // register port
   input  wire [`REG_ADDR_WIDTH-1:0] reg_addr_i,
   input  wire [`REG_DATA_WIDTH-1:0] reg_wdata_i,
   input  wire                      reg_write_i,
   input  wire                      reg_read_i,
   output reg  [`REG_DATA_WIDTH-1:0] reg_rdata_o
);

   // ***********************************************************************
   // states
   // ***********************************************************************
   localparam [0:0] ST_IDLE    = 1'b0;
   localparam [0:0] ST_REFETCH = 1'b1;

   reg                       state_reg;
   reg                       state_next;
   reg                       enable_reg;
   reg                       last_taken_reg;
   reg                       illegal_reg;
   reg  [`REG_DATA_WIDTH-1:0] taken_count_reg;
   reg  [`REG_DATA_WIDTH-1:0] not_taken_count_reg;
   reg  [`PC_WIDTH-1:0]      last_target_reg;
   reg  [`PC_WIDTH-1:0]      last_addr_reg;

   wire                      cond_true;
   wire                      sel_legal;
   wire [`PC_WIDTH-1:0]      target_addr;
   wire [`PC_WIDTH-1:0]      seq_addr;
   wire                      accept;
   wire                      go_taken;
   wire                      illegal_req;
   wire                      count_clr;
   wire                      ctrl_write;
   wire                      status_write;

   // ***********************************************************************
   // condition and address datapath
   // ***********************************************************************

   // flag test for the selected branch kind
   branch_cond_eval u_cond
   (
      .sel_i        (br_sel_i),
      .carry_i      (flag_carry_i),
      .negative_i   (flag_negative_i),
      .overflow_i   (flag_overflow_i),
      .half_carry_i (flag_half_carry_i),
      .transfer_i   (flag_transfer_i),
      .cond_o       (cond_true),
      .legal_o      (sel_legal)
   );

   // taken and fall-through addresses
   branch_target_add u_add
   (
      .addr_i     (br_addr_i),
      .offset_i   (br_offset_i),
      .target_o   (target_addr),
      .next_seq_o (seq_addr)
   );

   // ***********************************************************************
   // request acceptance
   // ***********************************************************************

   // requests during the refetch cycle are dropped: the decoder must stall
   assign accept      = br_valid_i & enable_reg & sel_legal & (state_reg == ST_IDLE);
   assign go_taken    = accept & cond_true;
   assign illegal_req = br_valid_i & enable_reg & ~sel_legal & (state_reg == ST_IDLE);
   assign br_busy_o   = (state_reg == ST_REFETCH);

   // ***********************************************************************
   // state machine
   // ***********************************************************************

   // taken costs one extra cycle, not taken finishes in one
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (go_taken)
               state_next = ST_REFETCH;                           // see [RULE13]
         end
         ST_REFETCH:
            state_next = ST_IDLE;                                 // see [RULE13]
         default:
            state_next = ST_IDLE;
      endcase
   end

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // ***********************************************************************
   // program counter outputs
   // ***********************************************************************

   // all outputs registered; done pulses once per accepted branch
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         br_done_o         <= 1'b0;
         br_taken_o        <= 1'b0;
         pc_load_o         <= 1'b0;
         program_counter_o <= `PC_RESET;
         fetch_flush_o     <= 1'b0;
         flag_write_en_o   <= 1'b0;
      end
      else
      begin
         br_done_o       <= accept;
         br_taken_o      <= go_taken;
         pc_load_o       <= go_taken;                             // see [RULE12]
         fetch_flush_o   <= go_taken;                             // see [RULE15]
         flag_write_en_o <= 1'b0;                                 // see [RULE13]
         if (accept)
         begin
            // fall-through still reported so the fetch side can check it
            if (cond_true)
               program_counter_o <= target_addr;                  // see [RULE12]
            else
               program_counter_o <= seq_addr;
         end
      end
   end

   // ***********************************************************************
   // software visible state
   // ***********************************************************************
   assign ctrl_write   = reg_write_i & (reg_addr_i == `REG_CTRL);
   assign status_write = reg_write_i & (reg_addr_i == `REG_STATUS);
   assign count_clr    = ctrl_write & reg_wdata_i[`CTRL_COUNT_CLR_BIT];

   // control: enable gates all branch evaluation
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         enable_reg <= `CTRL_RESET;
      else if (ctrl_write)
         enable_reg <= reg_wdata_i[`CTRL_ENABLE_BIT];
   end

   // illegal select is sticky; a new event wins over a write-one clear
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         illegal_reg <= 1'b0;
      else if (illegal_req)
         illegal_reg <= 1'b1;
      else if (status_write & reg_wdata_i[`STATUS_ILLEGAL_BIT])
         illegal_reg <= 1'b0;
   end

   // branch history for software
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         last_taken_reg  <= 1'b0;
         last_target_reg <= `PC_RESET;
         last_addr_reg   <= `PC_RESET;
      end
      else if (accept)
      begin
         last_taken_reg  <= cond_true;
         last_target_reg <= target_addr;
         last_addr_reg   <= br_addr_i;
      end
   end

   // counters wrap; a clear in the same cycle as a count loses the count
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         taken_count_reg     <= `COUNT_RESET;
         not_taken_count_reg <= `COUNT_RESET;
      end
      else if (count_clr)
      begin
         taken_count_reg     <= `COUNT_RESET;
         not_taken_count_reg <= `COUNT_RESET;
      end
      else if (accept)
      begin
         if (cond_true)
            taken_count_reg <= taken_count_reg + 16'h0001;
         else
            not_taken_count_reg <= not_taken_count_reg + 16'h0001;
      end
   end

   // ***********************************************************************
   // read port
   // ***********************************************************************

   // data stands for exactly the cycle after the strobe, zero otherwise
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= 16'h0000;
      else if (reg_read_i)
      begin
         case (reg_addr_i)
            `REG_CTRL:
               reg_rdata_o <= {15'h0000, enable_reg};
            `REG_STATUS:
               reg_rdata_o <= {13'h0000, illegal_reg, last_taken_reg, br_busy_o};
            `REG_TAKEN_COUNT:
               reg_rdata_o <= taken_count_reg;
            `REG_NOT_TAKEN_COUNT:
               reg_rdata_o <= not_taken_count_reg;
            `REG_LAST_TARGET:
               reg_rdata_o <= last_target_reg;
            `REG_LAST_ADDR:
               reg_rdata_o <= last_addr_reg;
            default:
               reg_rdata_o <= 16'h0000;
         endcase
      end
      else
         reg_rdata_o <= 16'h0000;
   end

endmodule

`default_nettype wire

// *** testbench/conditional_branch_unit_assertions.sv ***
`include "branch_unit_defines.vh"
`default_nettype none

// ***********************************************************************
// port checker for the branch unit
// ***********************************************************************
module conditional_branch_unit_assertions
(
   input wire logic                     core_clk_i,
   input wire logic                     reset_n_i,
   input wire logic                     br_valid_i,
   input wire logic [`SEL_WIDTH-1:0]    br_sel_i,
   input wire logic [`OFFSET_WIDTH-1:0] br_offset_i,
   input wire logic [`PC_WIDTH-1:0]     br_addr_i,
   input wire logic                     flag_carry_i,
   input wire logic                     flag_negative_i,
   input wire logic                     flag_overflow_i,
   input wire logic                     flag_half_carry_i,
   input wire logic                     flag_transfer_i,
   input wire logic                     br_done_o,
   input wire logic                     br_taken_o,
   input wire logic                     pc_load_o,
   input wire logic [`PC_WIDTH-1:0]     program_counter_o,
   input wire logic                     fetch_flush_o,
   input wire logic                     br_busy_o,
   input wire logic                     flag_write_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   // sign-extended offset, kept as a signal so $past sees a plain net
   wire logic [15:0] sext_off = {{9{br_offset_i[6]}}, br_offset_i};
   wire logic        cond_now;

   // reference condition per select code
   function automatic logic cond_f(input logic [3:0] s, input logic c, n, v, h, t);
      case (s)
         4'h0: cond_f = !c;
         4'h1: cond_f = c;
         4'h2: cond_f = n;
         4'h3: cond_f = !n;
         4'h4: cond_f = !(n ^ v);
         4'h5: cond_f = n ^ v;
         4'h6: cond_f = h;
         4'h7: cond_f = !h;
         4'h8: cond_f = t;
         4'h9: cond_f = !t;
         default: cond_f = v;
      endcase
   endfunction

   assign cond_now = cond_f(br_sel_i, flag_carry_i, flag_negative_i, flag_overflow_i,
                            flag_half_carry_i, flag_transfer_i);

   property p_done_cause;
      br_done_o |-> $past(br_valid_i) && !$past(br_busy_o) && ($past(br_sel_i) <= 4'ha);
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done without request");

   property p_cond;
      br_done_o |-> br_taken_o == $past(cond_now);
   endproperty
   a_cond: assert property (p_cond) else $error("wrong taken decision");

   property p_target;
      br_done_o && br_taken_o |-> program_counter_o == $past(br_addr_i) + $past(sext_off) + 16'h0001;
   endproperty
   a_target: assert property (p_target) else $error("wrong branch target");

   property p_seq;
      br_done_o && !br_taken_o |-> program_counter_o == $past(br_addr_i) + 16'h0001;
   endproperty
   a_seq: assert property (p_seq) else $error("wrong sequential address");

   property p_load;
      (pc_load_o || fetch_flush_o || br_taken_o) |-> (br_done_o && pc_load_o && fetch_flush_o && br_taken_o);
   endproperty
   a_load: assert property (p_load) else $error("load flush taken disagree");

   property p_busy;
      br_taken_o |-> br_busy_o ##1 !br_busy_o;
   endproperty
   a_busy: assert property (p_busy) else $error("taken stall not one cycle");

   property p_busy_cause;
      br_busy_o |-> br_taken_o;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("stall without taken branch");

   property p_noflag;
      1'b1 |-> !flag_write_en_o;
   endproperty
   a_noflag: assert property (p_noflag) else $error("flag write enabled");

   property p_pc_hold;
      !br_done_o |-> $stable(program_counter_o);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved without branch");
endmodule

bind conditional_branch_unit conditional_branch_unit_assertions i_chk
(
   .core_clk_i        (core_clk_i),
   .reset_n_i         (reset_n_i),
   .br_valid_i        (br_valid_i),
   .br_sel_i          (br_sel_i),
   .br_offset_i       (br_offset_i),
   .br_addr_i         (br_addr_i),
   .flag_carry_i      (flag_carry_i),
   .flag_negative_i   (flag_negative_i),
   .flag_overflow_i   (flag_overflow_i),
   .flag_half_carry_i (flag_half_carry_i),
   .flag_transfer_i   (flag_transfer_i),
   .br_done_o         (br_done_o),
   .br_taken_o        (br_taken_o),
   .pc_load_o         (pc_load_o),
   .program_counter_o (program_counter_o),
   .fetch_flush_o     (fetch_flush_o),
   .br_busy_o         (br_busy_o),
   .flag_write_en_o   (flag_write_en_o)
);

`default_nettype wire

// *** testbench/conditional_branch_unit_tb_top.sv ***
`include "branch_unit_defines.vh"
`default_nettype none

module conditional_branch_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************************************
   // stimulus and observation signals
   // ***********************************************************************
   logic        core_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        br_valid_i = 1'b0;
   logic [3:0]  br_sel_i = 4'h0;
   logic [6:0]  br_offset_i = 7'h00;
   logic [15:0] br_addr_i = 16'h0000;
   logic        flag_carry_i = 1'b0;
   logic        flag_negative_i = 1'b0;
   logic        flag_overflow_i = 1'b0;
   logic        flag_half_carry_i = 1'b0;
   logic        flag_transfer_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_write_i = 1'b0;
   logic        reg_read_i = 1'b0;
   wire         br_done_o;
   wire         br_taken_o;
   wire         pc_load_o;
   wire  [15:0] program_counter_o;
   wire         fetch_flush_o;
   wire         br_busy_o;
   wire         flag_write_en_o;
   wire  [15:0] reg_rdata_o;
   integer      seed = 32'h168c8712;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n_tk = 0;
   logic        last_tk = 1'b0;
   logic        rd_seen = 1'b0;
   logic [16:0] e;
   logic [16:0] bq[$];
   logic [15:0] rq[$];

   always #10 core_clk_i = ~core_clk_i;

   conditional_branch_unit i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .br_valid_i(br_valid_i), .br_sel_i(br_sel_i), .br_offset_i(br_offset_i),
      .br_addr_i(br_addr_i), .flag_carry_i(flag_carry_i), .flag_negative_i(flag_negative_i),
      .flag_overflow_i(flag_overflow_i), .flag_half_carry_i(flag_half_carry_i),
      .flag_transfer_i(flag_transfer_i), .br_done_o(br_done_o), .br_taken_o(br_taken_o),
      .pc_load_o(pc_load_o), .program_counter_o(program_counter_o),
      .fetch_flush_o(fetch_flush_o), .br_busy_o(br_busy_o), .flag_write_en_o(flag_write_en_o),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o));

   // ***********************************************************************
   // helpers
   // ***********************************************************************
   // flags packed as c n v h t, t in bit 0
   function automatic logic exp_cond(input logic [3:0] s, input logic [4:0] f);
      logic [15:0] tbl;
      tbl = {5'h00, f[2], ~f[0], f[0], ~f[1], f[1], f[3] ^ f[2], ~(f[3] ^ f[2]),
             ~f[3], f[3], f[4], ~f[4]};
      exp_cond = tbl[s];
   endfunction

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one request; a taken or refused one drops valid so spacing stays legal
   task automatic branch(input logic [3:0] s, input logic [6:0] k, input logic [15:0] a,
                         input logic [4:0] f, input logic en);
      logic acc;
      logic tk;
      acc = en && (s <= 4'ha);
      tk = exp_cond(s, f);
      br_valid_i <= 1'b1;
      br_sel_i <= s;
      br_offset_i <= k;
      br_addr_i <= a;
      {flag_carry_i, flag_negative_i, flag_overflow_i, flag_half_carry_i, flag_transfer_i} <= f;
      if (acc)
      begin
         bq.push_back({tk, tk ? a + {{9{k[6]}}, k} + 16'h0001 : a + 16'h0001});
         n_tk += int'(tk);
         last_tk = tk;
      end
      @(posedge core_clk_i);
      if (tk || !acc)
      begin
         br_valid_i <= 1'b0;
         @(posedge core_clk_i);
      end
   endtask

   task automatic reg_op(input logic wr, input logic [3:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      if (wr)
         reg_write_i <= 1'b1;
      else
      begin
         reg_read_i <= 1'b1;
         rq.push_back(d);
      end
      @(posedge core_clk_i);
      reg_write_i <= 1'b0;
      reg_read_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ***********************************************************************
   // monitor: pops the oldest note whenever a result shows
   // ***********************************************************************
   always @(posedge core_clk_i)
   begin
      if (rd_seen)
         check("rdata", reg_rdata_o, rq.pop_front());
      rd_seen = reg_read_i;
      if (br_done_o === 1'b1)
      begin
         if (bq.size() == 0)
            check("spurious done", 16'h0001, 16'h0000);
         else
         begin
            e = bq.pop_front();
            check("taken", {15'h0000, br_taken_o}, {15'h0000, e[16]});
            check("flush", {15'h0000, fetch_flush_o}, {15'h0000, e[16]});
            check("pc", program_counter_o, e[15:0]);
         end
      end
   end

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         conclude();
      end
   end

   // ***********************************************************************
   // main sequence
   // ***********************************************************************
   initial
   begin
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(posedge core_clk_i);
      reg_op(1'b0, `REG_CTRL, 16'h0001);
      reg_op(1'b0, 4'hf, 16'h0000);
      // every select code with random flags, offsets and addresses
      for (int i = 0; i < 88; i++)
         branch(4'(i % 11), 7'($random(seed)), 16'($random(seed)), 5'($random(seed)), 1'b1);
      // wrap past the top and a maximal backward jump
      branch(4'h8, 7'h3f, 16'hffff, 5'h01, 1'b1);
      branch(4'h4, 7'h40, 16'h0010, 5'h0c, 1'b1);
      br_valid_i <= 1'b0;
      // disabled unit and an illegal select give no result
      reg_op(1'b1, `REG_CTRL, 16'h0000);
      branch(4'h0, 7'h05, 16'h0100, 5'h00, 1'b0);
      reg_op(1'b1, `REG_CTRL, 16'h0001);
      branch(4'hb, 7'h05, 16'h0200, 5'h00, 1'b1);
      reg_op(1'b0, `REG_STATUS, {13'h0000, 1'b1, last_tk, 1'b0});
      reg_op(1'b1, `REG_STATUS, 16'h0004);
      reg_op(1'b0, `REG_STATUS, {13'h0000, 1'b0, last_tk, 1'b0});
      reg_op(1'b0, `REG_TAKEN_COUNT, 16'(n_tk));
      repeat (3) @(posedge core_clk_i);
      check("pending", 16'(bq.size() + rq.size()), 16'h0000);
      conclude();
   end
endmodule

`default_nettype wire
